// ==== verilog/tsq_regs.sv ====
`timescale 1ns/1ps
module tsq_regs (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic [7:0] i_io_addr,
  input  wire logic       i_io_rd,
  input  wire logic       i_io_wr,
  input  wire logic [7:0] i_io_wdata,
  output logic      [7:0] o_io_rdata,
  input  wire logic       i_attempt_end,
  input  wire logic       i_early_free_collision_err,
  input  wire logic       i_excess_collision_abort,
  input  wire logic       i_tx_data_starvation,
  input  wire logic       i_notify_request_flag,
  input  wire logic [7:0] i_frame_tag,
  input  wire logic       i_transmitter_on_set,
  input  wire logic       i_transmitter_clear,
  output logic            o_transmitter_on,
  output logic            o_transmit_buffer_halt,
  output logic      [7:0] o_current_frame_tag,
  input  wire logic       i_pattern_frame_hit,
  input  wire logic       i_addr_repeat_hit,
  input  wire logic       i_link_change,
  input  wire logic       i_pm_event_allow,
  input  wire logic       i_power_d0,
  output logic            o_wake_pin,
  output logic            o_pme_request,
  output logic            o_lan_wake_mode
);
  import tsq_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [4:0] ptr_inc(input logic [4:0] p);
    ptr_inc = (p == QPTR_LAST) ? 5'h00 : p + 5'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // outcome queue
  logic [7:0] mem [QDEPTH];
  logic [7:0] next_mem [QDEPTH];
  logic [4:0] rd_ptr, next_rd_ptr, wr_ptr, next_wr_ptr;
  logic [5:0] count, next_count;
  logic       ovf, next_ovf;
  logic       q_rd, q_wr, wk_rd, wk_wr;
  logic       err_any, push, pop;
  logic [7:0] new_byte, head_byte;

  assign q_rd  = i_io_rd && hit(i_io_addr, QUEUE_OFS);
  assign q_wr  = i_io_wr && hit(i_io_addr, QUEUE_OFS);
  assign wk_rd = i_io_rd && hit(i_io_addr, WAKE_OFS);
  assign wk_wr = i_io_wr && hit(i_io_addr, WAKE_OFS);

  assign err_any = i_early_free_collision_err | i_excess_collision_abort
                 | i_tx_data_starvation;
  // plain successes without a notify request leave no byte behind
  assign push = i_attempt_end && (err_any || i_notify_request_flag)
             && (count != QCOUNT_MAX);                                 // R8
  assign pop  = q_wr && (count != 6'h00);                              // R17

  always_comb begin
    new_byte             = 8'h00;
    new_byte[OB_RELEASE] = i_early_free_collision_err;               // R3
    new_byte[OB_EXCESS]  = i_excess_collision_abort;                 // R5
    new_byte[OB_UNDER]   = i_tx_data_starvation;                     // R6
    new_byte[OB_NOTIFY]  = i_notify_request_flag;                    // R7
    new_byte[OB_DONE]    = 1'b1;                                     // R8
  end

  always_comb begin
    head_byte = EMPTY_BYTE;                                          // R17
    if (count != 6'h00) begin
      head_byte         = mem[rd_ptr];                               // R1
      head_byte[OB_OVF] = ovf;                                       // R4
    end
  end

  always_comb begin
    next_mem    = mem;
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    next_count  = count;
    next_ovf    = ovf;
    if (push) begin
      next_mem[wr_ptr] = new_byte;                                   // R1
      next_wr_ptr      = ptr_inc(wr_ptr);
    end
    if (pop) begin
      next_rd_ptr = ptr_inc(rd_ptr);                                 // R2
    end
    if (push && !pop) begin
      next_count = count + 6'h01;
    end else if (pop && !push) begin
      next_count = count - 6'h01;
    end
    // a clearing write pops a nonempty queue, so no fill can keep the flag set
    if (q_wr) begin
      next_ovf = 1'b0;                                               // R4
    end
    if (push && !pop && (count == QCOUNT_MAX - 6'h01)) begin
      next_ovf = 1'b1;                                               // R4
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rd_ptr <= 5'h00;
      wr_ptr <= 5'h00;
      count  <= 6'h00;
      ovf    <= 1'b0;
    end else begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count  <= next_count;
      ovf    <= next_ovf;
    end
  end

  // payload needs no reset: empty reads never look at it
  always_ff @(posedge i_clk) begin
    mem <= next_mem;
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter control
  logic       tx_on, next_tx_on, buf_halt, next_buf_halt;
  logic [7:0] tag, next_tag;
  logic       stop_tx;

  assign stop_tx = next_ovf & ~ovf                                   // R4
                 | i_attempt_end & i_excess_collision_abort            // R5
                 | i_attempt_end & i_tx_data_starvation                // R6
                 | i_attempt_end & i_early_free_collision_err;         // R16

  always_comb begin
    next_tx_on    = tx_on;
    next_buf_halt = buf_halt;
    next_tag      = tag;
    if (i_transmitter_on_set) begin
      next_tx_on = 1'b1;
    end
    // a fault beats a same-cycle enable, so the host must enable again
    if (stop_tx) begin
      next_tx_on = 1'b0;
    end
    if (i_transmitter_clear) begin
      next_buf_halt = 1'b0;
    end
    if (i_attempt_end && i_tx_data_starvation) begin
      next_buf_halt = 1'b1;                                          // R6
    end
    if (i_attempt_end) begin
      next_tag = i_frame_tag;                                        // R16
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tx_on    <= TX_ON_RST;
      buf_halt <= 1'b0;
      tag      <= 8'h00;
    end else begin
      tx_on    <= next_tx_on;
      buf_halt <= next_buf_halt;
      tag      <= next_tag;
    end
  end

  assign o_transmitter_on       = tx_on;
  assign o_transmit_buffer_halt = buf_halt;
  assign o_current_frame_tag    = tag;

  ////////////////////////////////////////////////////////////////////////////
  // wake sources
  logic [7:0] wake, next_wake;
  logic       any_seen, wake_active, next_active;

  always_comb begin
    next_wake = wake;
    if (wk_wr) begin
      next_wake = (wake & ~WAKE_WMASK) | (i_io_wdata & WAKE_WMASK);
    end
    if (wk_rd) begin
      next_wake[WK_PAT_SEEN]  = 1'b0;                                // R14
      next_wake[WK_ADDR_SEEN] = 1'b0;                                // R14
      next_wake[WK_LINK_SEEN] = 1'b0;                                // R14
    end
    // set wins over the read clear, so no event is lost
    if (i_pattern_frame_hit && wake[WK_PAT]) begin
      next_wake[WK_PAT_SEEN] = 1'b1;                                 // R13
    end
    if (i_addr_repeat_hit && wake[WK_ADDR]) begin
      next_wake[WK_ADDR_SEEN] = 1'b1;                                // R13
    end
    if (i_link_change && wake[WK_LINK]) begin
      next_wake[WK_LINK_SEEN] = 1'b1;                                // R13
    end
  end

  assign any_seen = wake[WK_PAT_SEEN] & wake[WK_PAT]                 // R9
                  | wake[WK_ADDR_SEEN] & wake[WK_ADDR]               // R10
                  | wake[WK_LINK_SEEN] & wake[WK_LINK];              // R11
  assign next_active = any_seen
                     & (wake[WK_FORCE] | (i_pm_event_allow & ~i_power_d0)); // R15

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wake        <= WAKE_RST;                                       // R10
      wake_active <= 1'b0;
    end else begin
      wake        <= next_wake;
      wake_active <= next_active;
    end
  end

  assign o_pme_request   = wake_active;
  assign o_wake_pin      = wake_active ~^ wake[WK_SENSE];            // R12
  assign o_lan_wake_mode = wake[WK_FORCE];                           // R15

  ////////////////////////////////////////////////////////////////////////////
  // read data
  logic [7:0] rdata, next_rdata;

  always_comb begin
    next_rdata = rdata;
    if (q_rd) begin
      next_rdata = head_byte;                                        // R1
    end else if (wk_rd) begin
      next_rdata = wake;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign o_io_rdata = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_empty_read_zero: assert property (@(posedge i_clk) disable iff (i_reset) // R17
    q_rd && count == 6'h00 |=> o_io_rdata == EMPTY_BYTE)
    else $error("empty queue read not zero");
  a_pop_advances: assert property (@(posedge i_clk) disable iff (i_reset) // R2
    q_wr && count != 6'h00 && !push |=> count == $past(count) - 6'h01)
    else $error("write did not pop queue");
  a_push_valid: assert property (@(posedge i_clk) disable iff (i_reset) // R8
    q_rd && count != 6'h00 |=> o_io_rdata[OB_DONE])
    else $error("queued byte lacks done bit");
  a_count_bound: assert property (@(posedge i_clk) disable iff (i_reset) // R1
    count <= QCOUNT_MAX)
    else $error("queue count beyond depth");
  a_empty_pop_hold: assert property (@(posedge i_clk) disable iff (i_reset) // R17
    q_wr && count == 6'h00 && !push |=> count == 6'h00)
    else $error("empty pop changed queue");
  a_ovf_clears: assert property (@(posedge i_clk) disable iff (i_reset) // R4
    q_wr && !push |=> !ovf)
    else $error("queue write left overflow set");
  a_enable_on: assert property (@(posedge i_clk) disable iff (i_reset) // R5
    i_transmitter_on_set && !stop_tx |=> o_transmitter_on)
    else $error("enable pulse ignored");
  a_halt_release: assert property (@(posedge i_clk) disable iff (i_reset) // R6
    i_transmitter_clear && !(i_attempt_end && i_tx_data_starvation)
      |=> !o_transmit_buffer_halt)
    else $error("clear did not release halt");
  a_full_stops_tx: assert property (@(posedge i_clk) disable iff (i_reset) // R4
    $rose(ovf) |-> !o_transmitter_on && count == QCOUNT_MAX)
    else $error("full queue left transmitter on");
  a_excess_stops: assert property (@(posedge i_clk) disable iff (i_reset) // R5
    i_attempt_end && i_excess_collision_abort |=> !o_transmitter_on)
    else $error("excess collisions did not stop");
  a_starve_halts: assert property (@(posedge i_clk) disable iff (i_reset) // R6
    i_attempt_end && i_tx_data_starvation
      |=> !o_transmitter_on && o_transmit_buffer_halt)
    else $error("starvation did not halt");
  a_release_tag: assert property (@(posedge i_clk) disable iff (i_reset) // R16
    i_attempt_end && i_early_free_collision_err
      |=> !o_transmitter_on && o_current_frame_tag == $past(i_frame_tag))
    else $error("release error handling wrong");
  a_read_clears: assert property (@(posedge i_clk) disable iff (i_reset) // R14
    wk_rd && !i_pattern_frame_hit |=> !wake[WK_PAT_SEEN])
    else $error("wake read did not clear flag");
  a_seen_gated: assert property (@(posedge i_clk) disable iff (i_reset) // R13
    !wake[WK_LINK] && !wake[WK_LINK_SEEN] |=> !wake[WK_LINK_SEEN])
    else $error("link flag set while not allowed");
  a_reset_value: assert property (@(posedge i_clk) // R10
    $past(i_reset) && !i_reset |-> wake == WAKE_RST && o_wake_pin == 1'b0)
    else $error("wake register reset value wrong");
  a_d0_blocks: assert property (@(posedge i_clk) disable iff (i_reset) // R9
    i_power_d0 && !wake[WK_FORCE] |=> !o_pme_request)
    else $error("wake raised in D0");
  a_pin_follows: assert property (@(posedge i_clk) disable iff (i_reset) // R12
    wake[WK_SENSE] |-> o_wake_pin == o_pme_request)
    else $error("high sense pin not following wake");
  a_force_wakes: assert property (@(posedge i_clk) disable iff (i_reset) // R15
    wake[WK_FORCE] && wake[WK_LINK] && wake[WK_LINK_SEEN] |=> o_pme_request)
    else $error("forced mode did not wake");
endmodule

// ==== verilog/tsq_pkg.sv ====
// Summary of operation
// R1: queue of 31 outcome bytes, oldest read first
// R2: any write pops head, exposes next byte
// R3: bit 1 marks collision after early free
// R4: full queue sets bit 2, transmitter off
// R5: sixteen collisions set bit 3, transmitter stops
// R6: starvation sets bit 4, halts transmitter, buffer
// R7: bit 6 copies frame notify request flag
// R8: bit 7 marks valid outcome byte
// R9: pattern wake allow, gated, ignored in D0
// R10: repeated address wake allow, set at reset
// R11: link change wake allow, gated, ignored D0
// R12: bit 3 selects high wake pin, default
// R13: seen flags set only when allowed
// R14: reading wake register clears seen flags
// R15: bit 7 forces LAN wake mode
// R16: release error stops transmitter, exposes frame tag
// R17: empty read gives zero, empty pop ignored
package tsq_pkg;
  localparam logic [7:0] WAKE_OFS   = 8'h45;
  localparam logic [7:0] QUEUE_OFS  = 8'h46;
  localparam int         QDEPTH     = 31;
  localparam logic [5:0] QCOUNT_MAX = 6'h1f;
  localparam logic [4:0] QPTR_LAST  = 5'h1e;
  localparam logic [7:0] EMPTY_BYTE = 8'h00;
  // outcome byte fields
  localparam int OB_RELEASE = 1;
  localparam int OB_OVF     = 2;
  localparam int OB_EXCESS  = 3;
  localparam int OB_UNDER   = 4;
  localparam int OB_NOTIFY  = 6;
  localparam int OB_DONE    = 7;
  // wake register fields
  localparam int WK_PAT       = 0;
  localparam int WK_ADDR      = 1;
  localparam int WK_LINK      = 2;
  localparam int WK_SENSE     = 3;
  localparam int WK_PAT_SEEN  = 4;
  localparam int WK_ADDR_SEEN = 5;
  localparam int WK_LINK_SEEN = 6;
  localparam int WK_FORCE     = 7;
  localparam logic [7:0] WAKE_RST   = 8'h0a;
  localparam logic [7:0] WAKE_WMASK = 8'h8f;
  localparam logic       TX_ON_RST  = 1'b0;
endpackage

// ==== tb/tsq_host.sv ====
`timescale 1ns/1ps
// host driver side: one-cycle i/o strobes, byte wide
module tsq_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic      [7:0] o_addr,
  output logic            o_rd,
  output logic            o_wr,
  output logic      [7:0] o_wdata
);
  initial begin
    o_addr = 8'h00;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 8'h00;
  end
  // any data value pops the queue, so callers vary it on purpose
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
  // rdata is registered at the taking edge, so it is read just after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_clk);
    #1;
    o_rd = 1'b0;
    d = i_rdata;
  endtask
endmodule

// ==== tb/tx_status_queue_and_wake_events_tb.sv ====
`timescale 1ns/1ps
module tx_status_queue_and_wake_events_tb;
  import tsq_pkg::*;
  logic       i_clk = 1'b0;
  logic       i_reset = 1'b1;
  logic [7:0] addr, wdata, rdata, tag, v;
  logic [7:0] v_tag;
  logic       rd, wr, ton, thalt, pin, pme, lwm;
  logic [3:0] e = 4'h0;
  logic [1:0] c = 2'h0;
  logic [2:0] h = 3'h0;
  logic       att = 1'b0;
  logic       pm = 1'b1;
  logic       d0 = 1'b0;
  int         n_fail = 0;
  int         compares = 0;
  always #2.5 i_clk = ~i_clk;
  tsq_host u_tsq_host (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_rd(rd), .o_wr(wr),
    .o_wdata(wdata));
  tsq_regs u_tsq_regs (.i_clk(i_clk), .i_reset(i_reset), .i_io_addr(addr), .i_io_rd(rd),
    .i_io_wr(wr), .i_io_wdata(wdata), .o_io_rdata(rdata), .i_attempt_end(att),
    .i_early_free_collision_err(e[0]), .i_excess_collision_abort(e[1]),
    .i_tx_data_starvation(e[2]), .i_notify_request_flag(e[3]), .i_frame_tag(tag),
    .i_transmitter_on_set(c[0]), .i_transmitter_clear(c[1]), .o_transmitter_on(ton),
    .o_transmit_buffer_halt(thalt), .o_current_frame_tag(v_tag), .i_pattern_frame_hit(h[0]),
    .i_addr_repeat_hit(h[1]), .i_link_change(h[2]), .i_pm_event_allow(pm),
    .i_power_d0(d0), .o_wake_pin(pin), .o_pme_request(pme), .o_lan_wake_mode(lwm));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // attempt end with {notify, starvation, excess, release} and a tag
  task automatic attempt(input logic [3:0] ev, input logic [7:0] t);
    @(posedge i_clk);
    #1;
    att = 1'b1;
    e = ev;
    tag = t;
    @(posedge i_clk);
    #1;
    att = 1'b0;
    e = 4'h0;
  endtask
  task automatic ctl(input logic [1:0] cv);
    @(posedge i_clk);
    #1;
    c = cv;
    @(posedge i_clk);
    #1;
    c = 2'h0;
  endtask
  // flag lands one edge after the hit, the wake request one edge later
  task automatic hit(input logic [2:0] hv);
    @(posedge i_clk);
    #1;
    h = hv;
    @(posedge i_clk);
    #1;
    h = 3'h0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("tx_on", {7'h00, ton}, 8'h00);
    chk("pin", {7'h00, pin}, 8'h00);
    u_tsq_host.rd(WAKE_OFS, v);
    chk("wake_rst", v, WAKE_RST);
  endtask
  task automatic t_outcome();
    logic [7:0] exp [4] = '{8'hc0, 8'h82, 8'h88, 8'h90};
    ctl(2'b01);
    attempt(4'b1000, 8'h11);
    chk("on_notify", {7'h00, ton}, 8'h01);
    attempt(4'b0001, 8'h22);
    chk("on_release", {7'h00, ton}, 8'h00);
    chk("tag", v_tag, 8'h22);
    ctl(2'b01);
    attempt(4'b0010, 8'h33);
    chk("on_excess", {7'h00, ton}, 8'h00);
    ctl(2'b01);
    attempt(4'b0100, 8'h44);
    chk("halt", {6'h00, ton, thalt}, 8'h01);
    ctl(2'b10);
    chk("halt_clr", {7'h00, thalt}, 8'h00);
    attempt(4'b0000, 8'h55);
    for (int i = 0; i < 4; i++) begin
      u_tsq_host.rd(QUEUE_OFS, v);
      chk("head", v, exp[i]);
      u_tsq_host.wr(QUEUE_OFS, 8'(i * 37));
    end
    u_tsq_host.rd(QUEUE_OFS, v);
    chk("empty", v, EMPTY_BYTE);
    u_tsq_host.wr(QUEUE_OFS, 8'h00);
    attempt(4'b1000, 8'h66);
    u_tsq_host.rd(QUEUE_OFS, v);
    chk("after_empty_pop", v, 8'hc0);
    u_tsq_host.wr(QUEUE_OFS, 8'hff);
  endtask
  task automatic t_overflow();
    ctl(2'b01);
    repeat (30) attempt(4'b1000, 8'h01);
    u_tsq_host.rd(QUEUE_OFS, v);
    chk("thirty", v, 8'hc0);
    chk("thirty_on", {7'h00, ton}, 8'h01);
    attempt(4'b1000, 8'h02);
    u_tsq_host.rd(QUEUE_OFS, v);
    chk("full", v, 8'hc4);
    chk("full_off", {7'h00, ton}, 8'h00);
    attempt(4'b1000, 8'h03);
    u_tsq_host.wr(QUEUE_OFS, 8'h3c);
    ctl(2'b01);
    chk("reenable", {7'h00, ton}, 8'h01);
    repeat (30) begin
      u_tsq_host.rd(QUEUE_OFS, v);
      chk("drain", v, 8'hc0);
      u_tsq_host.wr(QUEUE_OFS, v);
    end
    u_tsq_host.rd(QUEUE_OFS, v);
    chk("dropped", v, EMPTY_BYTE);
  endtask
  task automatic t_wake();
    u_tsq_host.wr(WAKE_OFS, 8'hff);
    hit(3'b001);
    chk("pme_pin", {6'h00, pme, pin}, 8'h03);
    u_tsq_host.rd(WAKE_OFS, v);
    chk("seen", v, 8'h9f);
    u_tsq_host.wr(WAKE_OFS, 8'h0f);
    u_tsq_host.rd(WAKE_OFS, v);
    chk("rd_clear", v, 8'h0f);
    hit(3'b110);
    u_tsq_host.rd(WAKE_OFS, v);
    chk("addr_link", v, 8'h6f);
    u_tsq_host.wr(WAKE_OFS, 8'h00);
    hit(3'b111);
    chk("low_sense", {6'h00, pme, pin}, 8'h01);
    u_tsq_host.rd(WAKE_OFS, v);
    chk("masked", v, 8'h00);
    u_tsq_host.wr(WAKE_OFS, 8'h0f);
    d0 = 1'b1;
    hit(3'b001);
    chk("d0", {7'h00, pme}, 8'h00);
    u_tsq_host.rd(WAKE_OFS, v);
    chk("d0_seen", v, 8'h1f);
    pm = 1'b0;
    u_tsq_host.wr(WAKE_OFS, 8'h8f);
    hit(3'b100);
    chk("force", {6'h00, pme, lwm}, 8'h03);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tag = 8'h00;
    repeat (4) @(posedge i_clk);
    #1;
    i_reset = 1'b0;
    t_reset();
    t_outcome();
    t_overflow();
    t_wake();
    stop_test();
  end
  // bounded run: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    stop_test();
  end
endmodule
